// [csp_cfg.svh]
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH

// command byte fields
`define CSP_CMD_CH_HI 7
`define CSP_CMD_CH_LO 6
`define CSP_CMD_RD 5
`define CSP_CMD_T4 4
`define CSP_CMD_T3 3
`define CSP_CMD_CNT_HI 2
// storage sizes
`define CSP_CHANNELS 4
`define CSP_CHAN_REGS 6
`define CSP_COMMON_REGS 8
`define CSP_COEF_DEPTH 8
`define CSP_MAX_BYTES 8
// identification byte, value arbitrary
`define CSP_ID_CODE 8'h5a
// link timing of the controller end
`define CSP_CLK_NS 50
`define CSP_HALF_NS 500
`define CSP_HALF_CYC ((`CSP_HALF_NS + `CSP_CLK_NS - 1) / `CSP_CLK_NS)
// controller register offsets
`define CSP_A_CMD 8'h00
`define CSP_A_STATUS 8'h04
`define CSP_A_WLO 8'h08
`define CSP_A_WHI 8'h0c
`define CSP_A_RID 8'h10
`define CSP_A_RLO 8'h14
`define CSP_A_RHI 8'h18
`define CSP_A_ABORT 8'h1c
`endif

// [csp_pkg.sv]
package csp_pkg;
  typedef enum logic [1:0] {OP_STATUS, OP_EXTENDED, OP_COEF} op_t;
  typedef enum logic [1:0] {ST_CMD, ST_WR, ST_RD} dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END} host_state_t;
endpackage : csp_pkg

// [csp_link_if.sv]
`timescale 1ns/10ps
interface csp_link_if;
  logic csn;
  logic data_shift_clock;
  logic host_dout;
  logic host_oe;
  logic dev_dout;
  logic dev_oe;
  logic data_line;
  // strapped data line with a pull-up when nobody drives
  assign data_line = dev_oe ? dev_dout : (host_oe ? host_dout : 1'b1);
  modport dev(input csn, input data_shift_clock, input data_line, output dev_dout, output dev_oe);
  modport host(output csn, output data_shift_clock, output host_dout, output host_oe,
               input data_line);
endinterface : csp_link_if

// [csp_sync.sv]
`timescale 1ns/10ps
module csp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // foreign levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_reg_t;
  sync_reg_t r;
  sync_reg_t nxt_r;

  // first stage feeds only the second
  always_comb begin
    nxt_r.s1 = d;
    nxt_r.s2 = r.s1;
  end

  // link lines idle high, so reset to ones
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '1;
    end else begin
      r <= nxt_r;
    end
  end

  assign q = r.s2;
endmodule : csp_sync

// [csp_device.sv]
`timescale 1ns/10ps
`include "csp_cfg.svh"
module csp_device
  import csp_pkg::*;
#(
  parameter int CHANNELS = `CSP_CHANNELS,
  parameter int CHAN_REGS = `CSP_CHAN_REGS,
  parameter int COMMON_REGS = `CSP_COMMON_REGS,
  parameter int COEF_DEPTH = `CSP_COEF_DEPTH,
  parameter logic [7:0] ID_CODE = `CSP_ID_CODE // value arbitrary
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // serial control link
  csp_link_if.dev link,
  // configuration towards the codec core
  output logic [CHANNELS-1:0][CHAN_REGS-1:0][7:0] chan_cfg,
  output logic [COMMON_REGS-1:0][7:0] common_cfg,
  output logic cfg_write
);
  typedef struct packed {
    dev_state_t st;
    logic [7:0] sh;
    logic [2:0] bitn;
    logic [7:0] cmd;
    logic [2:0] idx;
    logic first;
    logic last;
    logic data_shift_clock_q;
    logic dout;
    logic oe;
    logic wr;
    logic [CHANNELS-1:0][CHAN_REGS-1:0][7:0] chan;
    logic [COMMON_REGS-1:0][7:0] common;
    logic [CHANNELS-1:0][COEF_DEPTH-1:0][7:0] coef;
  } dev_reg_t;

  localparam dev_reg_t RST = '{st: ST_CMD, sh: '0, bitn: '0, cmd: '0, idx: '0,
                               first: 1'b0, last: 1'b0, data_shift_clock_q: 1'b1, dout: 1'b1,
                               oe: 1'b0, wr: 1'b0, chan: '0, common: '0, coef: '0};

  dev_reg_t q;
  dev_reg_t nxt_q;
  logic csn_s;
  logic data_shift_clock_s;
  logic din_s;

  // link pins come from the controller's domain
  csp_sync #(
    .W(3)
  ) i_csp_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({link.csn, link.data_shift_clock, link.data_line}),
    .q({csn_s, data_shift_clock_s, din_s})
  );

  // operation type from bits 4 and 3
  function automatic op_t op_of(input logic [7:0] c);
    if (!c[`CSP_CMD_T4]) begin
      return OP_COEF;
    end
    return c[`CSP_CMD_T3] ? OP_EXTENDED : OP_STATUS;
  endfunction : op_of

  // one command interpreter, stepped by sampled edges of the link clock
  always_comb begin
    logic rise;
    logic fall;
    logic [7:0] byte_in;
    logic [7:0] rd_byte;
    logic [7:0] cur;
    logic [1:0] ch;
    rise = 1'b0;
    fall = 1'b0;
    byte_in = 8'h00;
    rd_byte = 8'h00;
    cur = 8'h00;
    ch = 2'h0;
    nxt_q = q;
    nxt_q.data_shift_clock_q = data_shift_clock_s;
    nxt_q.wr = 1'b0;
    rise = data_shift_clock_s & ~q.data_shift_clock_q;
    fall = ~data_shift_clock_s & q.data_shift_clock_q;
    byte_in = {q.sh[6:0], din_s};
    ch = q.cmd[`CSP_CMD_CH_HI:`CSP_CMD_CH_LO];
    // data byte for a read, chosen by type and index
    case (op_of(q.cmd))
      OP_STATUS: begin
        if (32'(q.idx) < CHAN_REGS) begin
          rd_byte = q.chan[ch][q.idx];
        end
      end
      OP_EXTENDED: begin
        if (32'(q.idx) < COMMON_REGS) begin
          rd_byte = q.common[q.idx];
        end
      end
      default: begin
        if (32'(q.idx) < COEF_DEPTH) begin
          rd_byte = q.coef[ch][q.idx];
        end
      end
    endcase
    if (csn_s) begin
      // deselect ends any sequence, even mid-byte
      nxt_q.st = ST_CMD;
      nxt_q.bitn = 3'h0;
      nxt_q.oe = 1'b0;
      nxt_q.dout = 1'b1;
    end else begin
      // only edges move the machine, so a held clock just waits
      case (q.st)
        ST_CMD: begin
          if (rise) begin
            nxt_q.sh = byte_in;
            nxt_q.bitn = q.bitn + 3'h1;
            if (q.bitn == 3'h7) begin
              nxt_q.cmd = byte_in;
              nxt_q.idx = byte_in[`CSP_CMD_CNT_HI:0];
              nxt_q.first = 1'b1;
              nxt_q.last = 1'b0;
              nxt_q.st = byte_in[`CSP_CMD_RD] ? ST_RD : ST_WR;
            end
          end
        end
        ST_WR: begin
          // output stays released while data comes in
          if (rise) begin
            nxt_q.sh = byte_in;
            nxt_q.bitn = q.bitn + 3'h1;
            if (q.bitn == 3'h7) begin
              nxt_q.wr = 1'b1;
              case (op_of(q.cmd))
                OP_STATUS: begin
                  if (32'(q.idx) < CHAN_REGS) begin
                    nxt_q.chan[ch][q.idx] = byte_in;
                  end
                end
                OP_EXTENDED: begin
                  if (32'(q.idx) < COMMON_REGS) begin
                    nxt_q.common[q.idx] = byte_in;
                  end
                end
                default: begin
                  if (32'(q.idx) < COEF_DEPTH) begin
                    nxt_q.coef[ch][q.idx] = byte_in;
                  end
                end
              endcase
              // count of at most eight ends at index zero
              if (q.idx == 3'h0) begin
                nxt_q.st = ST_CMD;
              end else begin
                nxt_q.idx = q.idx - 3'h1;
              end
            end
          end
        end
        ST_RD: begin
          // input is not looked at while answering
          if (rise && q.last) begin
            nxt_q.oe = 1'b0;
            nxt_q.dout = 1'b1;
            nxt_q.bitn = 3'h0;
            nxt_q.st = ST_CMD;
          end else if (fall && !q.last) begin
            if (q.bitn == 3'h0) begin
              cur = q.first ? ID_CODE : rd_byte;
            end else begin
              cur = q.sh;
            end
            nxt_q.dout = cur[7];
            nxt_q.oe = 1'b1;
            nxt_q.sh = {cur[6:0], 1'b0};
            nxt_q.bitn = q.bitn + 3'h1;
            if (q.bitn == 3'h7) begin
              if (q.first) begin
                nxt_q.first = 1'b0;
              end else if (q.idx == 3'h0) begin
                nxt_q.last = 1'b1;
              end else begin
                nxt_q.idx = q.idx - 3'h1;
              end
            end
          end
        end
        default: begin
          nxt_q.st = ST_CMD;
        end
      endcase
    end
  end

  // single state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= RST;
    end else begin
      q <= nxt_q;
    end
  end

  // outputs straight from the state register
  assign link.dev_dout = q.dout;
  assign link.dev_oe = q.oe;
  assign chan_cfg = q.chan;
  assign common_cfg = q.common;
  assign cfg_write = q.wr;
endmodule : csp_device

// [csp_host.sv]
`timescale 1ns/10ps
`include "csp_cfg.svh"
module csp_host
  import csp_pkg::*;
#(
  parameter int HALF_CYC = `CSP_HALF_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // serial control link
  csp_link_if.host link
);
  typedef struct packed {
    host_state_t st;
    logic [15:0] tmr;
    logic [2:0] bitn;
    logic [3:0] byten;
    logic [3:0] nbytes;
    logic [7:0] cmd;
    logic [7:0][7:0] wd;
    logic [8:0][7:0] rx;
    logic [7:0] rsh;
    logic csn;
    logic data_shift_clock;
    logic dout;
    logic oe;
    logic busy;
    logic done;
    logic av;
    logic aw;
    logic [7:0] aa;
    logic [31:0] rdata;
  } host_reg_t;

  localparam host_reg_t RST = '{st: H_IDLE, tmr: '0, bitn: '0, byten: '0, nbytes: '0,
                                cmd: '0, wd: '0, rx: '0, rsh: '0, csn: 1'b1,
                                data_shift_clock: 1'b1, dout: 1'b1, oe: 1'b0, busy: 1'b0,
                                done: 1'b0, av: 1'b0, aw: 1'b0, aa: '0, rdata: '0};

  host_reg_t q;
  host_reg_t nxt_q;
  logic line_s;

  // returned data comes from the device's domain
  csp_sync #(
    .W(1)
  ) i_csp_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(link.data_line),
    .q(line_s)
  );

  // link sequencer, then the bus slave on top
  always_comb begin
    logic half_done;
    logic go_low;
    logic rd;
    logic [7:0] snd;
    logic [7:0] b;
    half_done = 1'b0;
    go_low = 1'b0;
    rd = 1'b0;
    snd = 8'h00;
    b = 8'h00;
    nxt_q = q;
    rd = q.cmd[`CSP_CMD_RD];
    half_done = (32'(q.tmr) >= HALF_CYC - 1);
    nxt_q.tmr = q.tmr + 16'h1;
    b = {q.rsh[6:0], line_s};
    case (q.st)
      H_IDLE: begin
        nxt_q.tmr = 16'h0;
      end
      H_SETUP: begin
        go_low = half_done;
      end
      H_LOW: begin
        if (half_done) begin
          // sample on the rising edge we make
          nxt_q.tmr = 16'h0;
          nxt_q.data_shift_clock = 1'b1;
          nxt_q.st = H_HIGH;
          nxt_q.rsh = b;
          if (q.bitn == 3'h7 && rd && q.byten != 4'h0) begin
            nxt_q.rx[q.byten - 4'h1] = b;
          end
        end
      end
      // clock rests high until the half period ends
      H_HIGH: begin
        if (half_done) begin
          nxt_q.bitn = q.bitn + 3'h1;
          if (q.bitn == 3'h7) begin
            nxt_q.byten = q.byten + 4'h1;
          end
          if (q.bitn == 3'h7 && q.byten == q.nbytes - 4'h1) begin
            nxt_q.tmr = 16'h0;
            nxt_q.st = H_END;
          end else begin
            go_low = 1'b1;
          end
        end
      end
      H_END: begin
        if (half_done) begin
          nxt_q.csn = 1'b1;
          // let go of the shared line so the pull-up idles it
          nxt_q.oe = 1'b0;
          nxt_q.dout = 1'b1;
          nxt_q.busy = 1'b0;
          nxt_q.done = 1'b1;
          nxt_q.st = H_IDLE;
        end
      end
      default: begin
        nxt_q.st = H_IDLE;
      end
    endcase
    // falling edge: next bit out, released for read answers
    if (go_low) begin
      snd = (nxt_q.byten == 4'h0) ? q.cmd : q.wd[3'(nxt_q.byten - 4'h1)];
      nxt_q.tmr = 16'h0;
      nxt_q.st = H_LOW;
      nxt_q.data_shift_clock = 1'b0;
      nxt_q.dout = snd[3'h7 - nxt_q.bitn];
      nxt_q.oe = (nxt_q.byten == 4'h0) || !rd;
    end
    // data phase of a write
    if (q.av && q.aw) begin
      case (q.aa)
        `CSP_A_CMD: begin
          if (!q.busy) begin
            nxt_q.cmd = hwdata[7:0];
            // command, optional identification, then the data bytes
            nxt_q.nbytes = {1'b0, hwdata[`CSP_CMD_CNT_HI:0]} + (hwdata[`CSP_CMD_RD] ?
                           4'h3 : 4'h2);
            nxt_q.busy = 1'b1;
            nxt_q.done = 1'b0;
            nxt_q.csn = 1'b0;
            nxt_q.st = H_SETUP;
            nxt_q.tmr = 16'h0;
            nxt_q.bitn = 3'h0;
            nxt_q.byten = 4'h0;
          end
        end
        `CSP_A_WLO: nxt_q.wd[3:0] = hwdata;
        `CSP_A_WHI: nxt_q.wd[7:4] = hwdata;
        `CSP_A_ABORT: begin
          // deselect ends the device's sequence at once
          nxt_q.csn = 1'b1;
          nxt_q.data_shift_clock = 1'b1;
          nxt_q.oe = 1'b0;
          nxt_q.st = H_IDLE;
          nxt_q.busy = 1'b0;
        end
        default: begin
          nxt_q.av = 1'b0;
        end
      endcase
    end
    // address phase; read data ready in the data phase
    nxt_q.av = hsel && hready && htrans[1];
    nxt_q.aw = hwrite;
    nxt_q.aa = haddr[7:0];
    case (haddr[7:0])
      `CSP_A_CMD: nxt_q.rdata = {24'h0, q.cmd};
      `CSP_A_STATUS: nxt_q.rdata = {30'h0, q.done, q.busy};
      `CSP_A_WLO: nxt_q.rdata = q.wd[3:0];
      `CSP_A_WHI: nxt_q.rdata = q.wd[7:4];
      `CSP_A_RID: nxt_q.rdata = {24'h0, q.rx[0]};
      `CSP_A_RLO: nxt_q.rdata = q.rx[4:1];
      `CSP_A_RHI: nxt_q.rdata = q.rx[8:5];
      default: nxt_q.rdata = 32'h0;
    endcase
  end

  // single state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= RST;
    end else begin
      q <= nxt_q;
    end
  end

  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign link.csn = q.csn;
  assign link.data_shift_clock = q.data_shift_clock;
  assign link.host_dout = q.dout;
  assign link.host_oe = q.oe;
endmodule : csp_host

// [csp_link_assertions.sv]
`timescale 1ns/10ps
module csp_link_assertions (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link wires
  input wire logic csn,
  input wire logic data_shift_clock,
  input wire logic host_dout,
  input wire logic host_oe,
  input wire logic dev_dout,
  input wire logic dev_oe,
  input wire logic data_line
);
  logic data_shift_clock_d_ff;
  logic [6:0] rises_ff;

  // link rises per select; saturates so overlong frames still show
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_shift_clock_d_ff <= 1'b1;
      rises_ff <= 7'h00;
    end else begin
      data_shift_clock_d_ff <= data_shift_clock;
      if (csn) begin
        rises_ff <= 7'h00;
      end else if (data_shift_clock && !data_shift_clock_d_ff && rises_ff != 7'h7f) begin
        rises_ff <= rises_ff + 7'h01;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // frame opening: select falls, clock holds high for setup
  sequence s_select;
    $fell(csn);
  endsequence
  sequence s_setup;
    data_shift_clock [*8];
  endsequence

  property p_setup;
    s_select |-> s_setup;
  endproperty
  a_setup: assert property (p_setup)
    else $error("link clock moved during select setup");
  property p_no_clash;
    dev_oe |-> !host_oe;
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the data line");
  property p_unselected_quiet;
    csn [*5] |-> !dev_oe && data_line;
  endproperty
  a_unselected_quiet: assert property (p_unselected_quiet)
    else $error("data line driven while unselected");
  property p_idle_clock;
    csn && $past(csn) |-> data_shift_clock;
  endproperty
  a_idle_clock: assert property (p_idle_clock)
    else $error("link clock not idle high between frames");
  property p_dev_dout_fall;
    dev_oe && $past(dev_oe) && $changed(dev_dout) |-> !data_shift_clock;
  endproperty
  a_dev_dout_fall: assert property (p_dev_dout_fall)
    else $error("device data changed while link clock high");
  property p_host_dout_fall;
    host_oe && $past(host_oe) && $changed(host_dout) |-> !data_shift_clock;
  endproperty
  a_host_dout_fall: assert property (p_host_dout_fall)
    else $error("host data changed while link clock high");
  property p_answer_after_cmd;
    dev_oe |-> rises_ff >= 7'd8;
  endproperty
  a_answer_after_cmd: assert property (p_answer_after_cmd)
    else $error("device drove before a whole command byte");
  property p_answer_start;
    $rose(dev_oe) |-> !data_shift_clock && rises_ff == 7'd8;
  endproperty
  a_answer_start: assert property (p_answer_start)
    else $error("answer not started on the fall after the command");
  property p_release;
    $fell(dev_oe) |-> data_shift_clock || csn;
  endproperty
  a_release: assert property (p_release)
    else $error("device released the line while clock low");
  property p_frame_len;
    $rose(csn) |-> rises_ff <= 7'd80;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame longer than command, id and eight bytes");
endmodule : csp_link_assertions

// [codec_serial_control_port_test.sv]
`timescale 1ns/10ps
`include "csp_cfg.svh"
module codec_serial_control_port_test;
  import csp_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = '0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic chk_a = 1'b0;
  logic rd_dp = 1'b0;
  logic chk_dp = 1'b0;
  logic [63:0] exp_q[$];
  logic [63:0] ex;
  logic [31:0] seed = 32'hb2d1e9a3;
  int fails = 0;
  int tests_run = 0;
  int wr_pulses = 0;
  logic [3:0][5:0][7:0] chan_cfg;
  logic [7:0][7:0] common_cfg;
  logic cfg_write;

  csp_link_if i_csp_link_if();
  csp_host i_csp_host(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .link(i_csp_link_if));
  csp_device i_csp_device(.hclk, .hresetn, .link(i_csp_link_if), .chan_cfg(chan_cfg),
    .common_cfg(common_cfg), .cfg_write(cfg_write));
  csp_link_assertions i_csp_link_assertions(.hclk, .hresetn,
    .csn(i_csp_link_if.csn), .data_shift_clock(i_csp_link_if.data_shift_clock),
    .host_dout(i_csp_link_if.host_dout), .host_oe(i_csp_link_if.host_oe),
    .dev_dout(i_csp_link_if.dev_dout), .dev_oe(i_csp_link_if.dev_oe),
    .data_line(i_csp_link_if.data_line));

  initial begin
    forever #25 hclk = ~hclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task summarize();
    if (fails == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  // one single word transfer; read data taken at the data phase edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      input logic chk, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    chk_a <= chk;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    chk_a <= 1'b0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin
      fails++;
      summarize();
    end
  endtask : xfer

  // direct compare of a design output against the rule's value
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_val

  // note the masked expectation, then read
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    exp_q.push_back({m, e});
    xfer(1'b0, a, 32'h0, 1'b1, d);
  endtask : chk_rd

  task automatic load(input logic [7:0] cmd, input logic [63:0] w);
    logic [31:0] d;
    xfer(1'b1, `CSP_A_WLO, w[31:0], 1'b0, d);
    xfer(1'b1, `CSP_A_WHI, w[63:32], 1'b0, d);
    xfer(1'b1, `CSP_A_CMD, {24'h0, cmd}, 1'b0, d);
  endtask : load

  // polls busy; a hung link ends the run
  task automatic run(input logic [7:0] cmd, input logic [63:0] w);
    logic [31:0] d;
    int n;
    n = 0;
    load(cmd, w);
    do begin
      xfer(1'b0, `CSP_A_STATUS, 32'h0, 1'b0, d);
      n++;
    end while (d[0] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      fails++;
      summarize();
    end
  endtask : run

  // compare every noted read against the oldest note
  always @(posedge hclk) begin
    if (rd_dp && chk_dp && hreadyout === 1'b1) begin
      ex = exp_q.pop_front();
      tests_run++;
      if ((hrdata & ex[63:32]) !== ex[31:0]) begin
        fails++;
        $display("ERROR t=%0t got %h exp %h", $time, hrdata & ex[63:32], ex[31:0]);
      end
    end
    // one pulse per whole data byte, stored or out of range; partial bytes must not count
    if (cfg_write === 1'b1) wr_pulses++;
    rd_dp <= hsel & htrans[1] & ~hwrite & hreadyout;
    chk_dp <= chk_a;
  end

  initial begin
    logic [63:0] w;
    logic [63:0] e;
    logic [31:0] keep;
    logic [31:0] d;
    logic [7:0] cmd;
    int n;
    int m;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    chk_rd(8'h20, 32'hffffffff, 32'h0);
    xfer(1'b1, 8'h24, rnd(), 1'b0, d);
    chk_rd(8'h24, 32'hffffffff, 32'h0);
    // status, extended, coefficient on channels 1..3
    for (int t = 0; t < 3; t++) begin
      cmd = (t == 0) ? 8'h10 : (t == 1) ? 8'h18 : 8'h00;
      cmd = cmd | 8'((t + 1) << 6);
      n = (t == 0) ? 6 : 8;
      m = (t == 1) ? 8 : 4;
      w = {rnd(), rnd()};
      run(cmd | 8'(n - 1), w);
      if (t == 0) chk_val({24'h0, chan_cfg[1][5]}, {24'h0, w[7:0]});
      if (t == 0) chk_val({24'h0, chan_cfg[1][0]}, {24'h0, w[47:40]});
      if (t == 1) chk_val({24'h0, common_cfg[7]}, {24'h0, w[7:0]});
      if (t == 1) chk_val({24'h0, common_cfg[0]}, {24'h0, w[63:56]});
      e = w >> (8 * (n - m));
      if (t == 0) keep = e[31:0];
      run(cmd | 8'h20 | 8'(m - 1), 64'h0);
      chk_rd(`CSP_A_RID, 32'hff, {24'h0, `CSP_ID_CODE});
      chk_rd(`CSP_A_RLO, 32'hffffffff, e[31:0]);
      if (m == 8) chk_rd(`CSP_A_RHI, 32'hffffffff, e[63:32]);
      // neighbour channel: common set shared, the rest kept apart
      run((cmd ^ 8'h40) | 8'h20 | 8'(m - 1), 64'h0);
      chk_rd(`CSP_A_RLO, 32'hffffffff, (t == 1) ? e[31:0] : 32'h0);
    end
    chk_rd(`CSP_A_STATUS, 32'h3, 32'h2);
    // abort a status write inside its first data byte
    load(8'h55, {rnd(), rnd()});
    repeat (200) @(posedge hclk);
    xfer(1'b1, `CSP_A_ABORT, 32'h1, 1'b0, d);
    run(8'h73, 64'h0);
    chk_rd(`CSP_A_RLO, 32'hffffffff, keep);
    // six, eight and eight bytes stored; the cut byte is dropped
    chk_val(32'(wr_pulses), 32'h16);
    summarize();
  end
endmodule : codec_serial_control_port_test
